// >>> pkg/asr_pkg.sv
package asr_pkg;
   // memory shape
   localparam int ADDR_W = 19;
   localparam int DATA_W = 8;
   // clock
   localparam int CLK_NS = 50;
   // speed grade timings, faster grade (ns)
   localparam int READ_PERIOD_MIN_NS   = 55;
   localparam int ACCESS_MAX_NS        = 55;
   localparam int WRITE_PULSE_MIN_NS   = 40;
   localparam int DATA_OVERLAP_MIN_NS  = 25;
   localparam int WRITE_TO_FLOAT_MAX_NS = 20;
   localparam int ADDR_TO_END_MIN_NS   = 50;
   localparam int RETENTION_RECOVERY_NS = READ_PERIOD_MIN_NS;
   // least times round up, never below one cycle
   function automatic int asr_cyc(input int ns);
      int c;
      c = (ns + CLK_NS - 1) / CLK_NS;
      return (c < 1) ? 1 : c;
   endfunction : asr_cyc
   // write pulse must cover overlap plus float time, whichever is larger
   localparam int WP_NS = (WRITE_PULSE_MIN_NS > DATA_OVERLAP_MIN_NS + WRITE_TO_FLOAT_MAX_NS)
                          ? WRITE_PULSE_MIN_NS : DATA_OVERLAP_MIN_NS + WRITE_TO_FLOAT_MAX_NS;
   localparam int WP_CYC  = (asr_cyc(WP_NS) > asr_cyc(ADDR_TO_END_MIN_NS))
                          ? asr_cyc(WP_NS) : asr_cyc(ADDR_TO_END_MIN_NS);
   localparam int RD_CYC  = asr_cyc(ACCESS_MAX_NS) + 4; // plus sync stages, filter and capture
   localparam int GAP_CYC = asr_cyc(READ_PERIOD_MIN_NS);
   localparam int REC_CYC = asr_cyc(RETENTION_RECOVERY_NS);
   localparam int CNT_W   = 4;
   // pins toward the memory
   typedef struct packed {
      logic [ADDR_W-1:0] word_addr;
      logic              chip_sel_n;
      logic              out_en_n;
      logic              wr_en_n;
   } asr_pins_t;
   // request from the user
   typedef struct packed {
      logic              write;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } asr_req_t;
endpackage : asr_pkg

// >>> design/asr_sync.sv
// three flop synchroniser; a change counts once stages two and three agree
module asr_sync
   import asr_pkg::*;
#(
   parameter int W = 8
) (
   input  wire logic         clk,
   input  wire logic         resetn,
   input  wire logic [W-1:0] din,
   output logic      [W-1:0] dout
);
   logic [W-1:0] s1;
   logic [W-1:0] s2;
   logic [W-1:0] s3;

   // shift chain and agreement filter
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         s1   <= '0;
         s2   <= '0;
         s3   <= '0;
         dout <= '0;
      end else begin
         s1 <= din;
         s2 <= s1;
         s3 <= s2;
         if (s2 == s3) begin
            dout <= s3;
         end
      end
   end
endmodule : asr_sync

// >>> design/asr_ctrl.sv
// Function
// - accesses spaced by one cycle time
// - write pulse at least 40 ns
// - address stable before write starts
// - select low 50 ns to end of write
// - data valid 25 ns before write end
// - address held through write recovery
// - never fight the device on the bus
// - pulse covers overlap plus float time
// - deselect for retention, recover one cycle
module asr_ctrl
   import asr_pkg::*;
(
   input  wire logic              clk,
   input  wire logic              resetn,
   input  wire logic              req_valid,
   output logic                   req_ready,
   input  wire asr_req_t          req,
   output logic                   rsp_valid,
   output logic      [DATA_W-1:0] rsp_data,
   input  wire logic              retain_req,
   output logic                   retain_ack,
   output asr_pins_t              pins,
   input  wire logic [DATA_W-1:0] bus_in,
   output logic      [DATA_W-1:0] bus_out,
   output logic                   bus_oe_n
);
   typedef enum logic [2:0] {
      ASR_IDLE, ASR_READ, ASR_WSET, ASR_WPULSE, ASR_WREC, ASR_GAP, ASR_RETAIN, ASR_RECOVER
   } asr_state_t;

   asr_state_t        state;
   logic [CNT_W-1:0]  cnt;
   logic [DATA_W-1:0] bus_sync;

   asr_sync #(.W(DATA_W)) u_sync (
      .clk    (clk),
      .resetn (resetn),
      .din    (bus_in),
      .dout   (bus_sync)
   );

   assign req_ready  = (state == ASR_IDLE) && !retain_req;
   assign retain_ack = (state == ASR_RETAIN);

   // sequencer: each access ends with a spacing gap
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         state <= ASR_IDLE;
         cnt   <= '0;
      end else begin
         case (state)
            ASR_IDLE: begin
               if (retain_req) begin
                  state <= ASR_RETAIN;
               end else if (req_valid) begin
                  state <= req.write ? ASR_WSET : ASR_READ;
                  cnt   <= CNT_W'(RD_CYC - 1);
               end
            end
            ASR_READ: begin
               if (cnt == '0) begin
                  state <= ASR_GAP;
                  cnt   <= CNT_W'(GAP_CYC - 1);
               end else begin
                  cnt <= cnt - 1'b1;
               end
            end
            ASR_WSET: begin
               state <= ASR_WPULSE;
               cnt   <= CNT_W'(WP_CYC - 1);
            end
            ASR_WPULSE: begin
               if (cnt == '0) begin
                  state <= ASR_WREC;
               end else begin
                  cnt <= cnt - 1'b1;
               end
            end
            ASR_WREC: begin
               state <= ASR_GAP;
               cnt   <= CNT_W'(GAP_CYC - 1);
            end
            ASR_GAP: begin
               if (cnt == '0) begin
                  state <= ASR_IDLE;
               end else begin
                  cnt <= cnt - 1'b1;
               end
            end
            ASR_RETAIN: begin
               if (!retain_req) begin
                  state <= ASR_RECOVER;
                  cnt   <= CNT_W'(REC_CYC - 1);
               end
            end
            ASR_RECOVER: begin
               if (cnt == '0) begin
                  state <= ASR_IDLE;
               end else begin
                  cnt <= cnt - 1'b1;
               end
            end
            default: begin
               state <= ASR_IDLE;
            end
         endcase
      end
   end

   // address and write data latched at acceptance, held through recovery
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         pins.word_addr <= '0;
         bus_out        <= '0;
      end else if (state == ASR_IDLE && req_valid && !retain_req) begin
         pins.word_addr <= req.addr;
         bus_out        <= req.wdata;
      end
   end

   // control strobes from the next state
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         pins.chip_sel_n <= 1'b1;
         pins.out_en_n   <= 1'b1;
         pins.wr_en_n    <= 1'b1;
         bus_oe_n        <= 1'b1;
      end else begin
         case (state)
            ASR_IDLE: begin
               pins.chip_sel_n <= !(req_valid && !retain_req);
               pins.out_en_n   <= !(req_valid && !retain_req && !req.write);
               pins.wr_en_n    <= 1'b1;
               bus_oe_n        <= 1'b1;
            end
            ASR_READ: begin
               pins.chip_sel_n <= (cnt == '0);
               pins.out_en_n   <= (cnt == '0);
            end
            ASR_WSET: begin
               pins.wr_en_n <= 1'b0;
               bus_oe_n     <= 1'b0;
            end
            ASR_WPULSE: begin
               if (cnt == '0) begin
                  pins.wr_en_n <= 1'b1;
               end
            end
            ASR_WREC: begin
               pins.chip_sel_n <= 1'b1;
               bus_oe_n        <= 1'b1;
            end
            default: begin
               pins.chip_sel_n <= 1'b1;
               pins.out_en_n   <= 1'b1;
               pins.wr_en_n    <= 1'b1;
               bus_oe_n        <= 1'b1;
            end
         endcase
      end
   end

   // read data captured after the synchroniser has settled
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rsp_valid <= 1'b0;
         rsp_data  <= '0;
      end else begin
         rsp_valid <= 1'b0; // answer stands for one cycle only
         if (state == ASR_READ && cnt == '0) begin
            rsp_data  <= bus_sync;
            rsp_valid <= 1'b1;
         end
      end
   end

   a_write_under_sel: assert property (@(posedge clk) disable iff (!resetn)
      !pins.wr_en_n |-> !pins.chip_sel_n && pins.out_en_n)
      else $error("write strobe outside chip select");
   // write steps: strobe low with data driven, then strobe high while still selected
   sequence s_write_pulse;
      !pins.wr_en_n && !pins.chip_sel_n && !bus_oe_n;
   endsequence
   sequence s_write_end;
      pins.wr_en_n && !pins.chip_sel_n && !bus_oe_n;
   endsequence

   a_write_width: assert property (@(posedge clk) disable iff (!resetn)
      $fell(pins.wr_en_n) |-> s_write_pulse ##1 s_write_end)
      else $error("write pulse too short");
   a_write_setup: assert property (@(posedge clk) disable iff (!resetn)
      $fell(pins.wr_en_n) |-> !$past(pins.chip_sel_n))
      else $error("write started before select and address");
   a_rsp_pulse: assert property (@(posedge clk) disable iff (!resetn)
      rsp_valid |=> !rsp_valid)
      else $error("read answer longer than one cycle");
   a_no_contention: assert property (@(posedge clk) disable iff (!resetn)
      !bus_oe_n |-> pins.out_en_n)
      else $error("driving bus while device may drive");
   a_addr_stable: assert property (@(posedge clk) disable iff (!resetn)
      !pins.chip_sel_n && $past(!pins.chip_sel_n) |-> $stable(pins.word_addr))
      else $error("address moved during access");
   a_write_data: assert property (@(posedge clk) disable iff (!resetn)
      !pins.wr_en_n |-> !bus_oe_n && $stable(bus_out))
      else $error("write data not held");
   a_retain_desel: assert property (@(posedge clk) disable iff (!resetn)
      retain_ack |-> pins.chip_sel_n)
      else $error("chip selected in retention");
   a_access_gap: assert property (@(posedge clk) disable iff (!resetn)
      $rose(pins.chip_sel_n) |-> pins.chip_sel_n [*2])
      else $error("accesses too close");
   a_read_len: assert property (@(posedge clk) disable iff (!resetn)
      $fell(pins.out_en_n) |-> !pins.out_en_n [*6])
      else $error("read too short");
endmodule : asr_ctrl

// >>> tb/asr_sram_model.sv
// behavioural byte-wide static memory seen from its pins
module asr_sram_model
   import asr_pkg::*;
(
   input  wire logic              clk,
   input  wire asr_pins_t         pins,
   input  wire logic [DATA_W-1:0] bus_out,
   input  wire logic              bus_oe_n,
   output logic      [DATA_W-1:0] bus_in,
   output int                     faults
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [DATA_W-1:0] mem [logic [ADDR_W-1:0]];
   logic [DATA_W-1:0] last = 8'h00;
   logic [DATA_W-1:0] wdata;
   logic [ADDR_W-1:0] waddr;
   logic              drive, wr, wr_q = 1'b0, drive_q = 1'b0;
   logic [ADDR_W-1:0] addr_q;
   int                wcnt = 0;
   // outputs drive only when selected, enabled and not writing
   assign drive = !pins.chip_sel_n && !pins.out_en_n && pins.wr_en_n;
   assign wr = !pins.chip_sel_n && !pins.wr_en_n;
   // a floating bus shows the inverse of the last driven byte
   always @* begin
      if (drive) bus_in = mem.exists(pins.word_addr) ? mem[pins.word_addr] : 8'h00;
      else bus_in = ~last;
   end
   // write window tracking and contention checks
   always @(posedge clk) begin
      if (drive) last <= bus_in;
      drive_q <= drive;
      addr_q <= pins.word_addr;
      // address must not move while the outputs drive, old data would hold a while
      if (drive && drive_q && pins.word_addr !== addr_q) faults++;
      wr_q <= wr;
      if (drive && bus_oe_n === 1'b0) faults++;
      if (wr) begin
         wcnt <= wcnt + 1;
         wdata <= bus_out;
         waddr <= pins.word_addr;
         if (bus_oe_n !== 1'b0) faults++;
         if (wr_q && pins.word_addr !== waddr) faults++;
      end else begin
         wcnt <= 0;
      end
      // array changes only at the end of the write window
      if (wr_q && !wr) begin
         mem[waddr] = wdata;
         if (wcnt < WP_CYC) faults++;
      end
   end
endmodule : asr_sram_model

// >>> tb/tb_asr_ctrl.sv
module tb_asr_ctrl
   import asr_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic              clk = 1'b0, resetn = 1'b0, req_valid = 1'b0, retain_req = 1'b0;
   asr_req_t          req = '0;
   logic              req_ready, rsp_valid, retain_ack, bus_oe_n;
   logic [DATA_W-1:0] rsp_data, bus_out, bus_in;
   asr_pins_t         pins;
   int                faults;
   int                err_count = 0, checked = 0;
   // 20 MHz clock
   always #25 clk = ~clk;
   asr_ctrl u_asr_ctrl (.clk(clk), .resetn(resetn), .req_valid(req_valid),
      .req_ready(req_ready), .req(req), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
      .retain_req(retain_req), .retain_ack(retain_ack), .pins(pins), .bus_in(bus_in),
      .bus_out(bus_out), .bus_oe_n(bus_oe_n));
   asr_sram_model u_asr_sram_model (.clk(clk), .pins(pins), .bus_out(bus_out),
      .bus_oe_n(bus_oe_n), .bus_in(bus_in), .faults(faults));
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (g !== e) begin
         err_count++;
         $display("ERROR %s expected %0h seen %0h", nm, e, g);
      end
   endtask : chk
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", checked, err_count);
      if (err_count == 0 && checked > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : report_and_stop
   task automatic tmo();
      err_count++;
      $display("ERROR wait expected done seen timeout");
      report_and_stop();
   endtask : tmo
   // one access; lat counts cycles from take to answer or ready
   task automatic access(input logic w, input logic [ADDR_W-1:0] a,
      input logic [DATA_W-1:0] d, output logic [DATA_W-1:0] q, output int lat);
      int n;
      @(posedge clk);
      req_valid <= 1'b1;
      req <= '{w, a, d};
      n = 0;
      do begin
         @(negedge clk);
         n++;
         if (n > 50) tmo();
      end while (req_ready !== 1'b1);
      @(posedge clk);
      req_valid <= 1'b0;
      lat = 0;
      q = 'x;
      for (n = 1; n <= 20 && lat == 0; n++) begin
         @(negedge clk);
         if (w ? req_ready === 1'b1 : rsp_valid === 1'b1) begin
            lat = n;
            q = rsp_data;
         end
      end
      if (lat == 0) tmo();
   endtask : access
   task automatic t_reset();
      repeat (6) @(posedge clk);
      @(negedge clk);
      chk("cs_rst", 1, pins.chip_sel_n);
      chk("oe_rst", 1, bus_oe_n);
      chk("rsp_rst", 0, rsp_valid);
      @(posedge clk);
      resetn <= 1'b1;
      $display("test reset done");
   endtask : t_reset
   task automatic t_rdwr();
      logic [ADDR_W-1:0] ad [4] = '{19'h00000, 19'h7ffff, 19'h12345, 19'h00000};
      logic [DATA_W-1:0] dt [4] = '{8'ha5, 8'h3c, 8'hff, 8'h5a};
      logic [DATA_W-1:0] q;
      int                lat;
      for (int i = 0; i < 4; i++) begin
         access(1'b1, ad[i], dt[i], q, lat);
         chk("wr_lat", 3 + WP_CYC + GAP_CYC, lat);
      end
      for (int i = 1; i < 4; i++) begin
         access(1'b0, ad[i], 8'h00, q, lat);
         chk("rd_lat", RD_CYC + 1, lat);
         chk("rd_data", dt[i], q);
      end
      chk("faults", 0, faults);
      $display("test read write done");
   endtask : t_rdwr
   task automatic t_retain();
      logic [DATA_W-1:0] q;
      int                n, lat;
      @(posedge clk);
      retain_req <= 1'b1;
      n = 0;
      do begin
         @(negedge clk);
         n++;
         if (n > 50) tmo();
      end while (retain_ack !== 1'b1);
      chk("cs_ret", 1, pins.chip_sel_n);
      chk("rdy_ret", 0, req_ready);
      @(posedge clk);
      retain_req <= 1'b0;
      n = 0;
      do begin
         @(negedge clk);
         n++;
         if (n > 50) tmo();
      end while (req_ready !== 1'b1);
      chk("recover", REC_CYC + 2, n);
      access(1'b0, 19'h7ffff, 8'h00, q, lat);
      chk("kept", 8'h3c, q);
      chk("faults_ret", 0, faults);
      $display("test retention done");
   endtask : t_retain
   initial begin
      t_reset();
      t_rdwr();
      t_retain();
      report_and_stop();
   end
endmodule : tb_asr_ctrl
